/* File: rtl/arcfp_fault_mem.sv */
// fault record memory with registered read data
`timescale 1ns/1ps
module arcfp_fault_mem
    import arcfp_pkg::*;
#(
    parameter int W = REC_W,
    parameter int DEPTH = REC_DEPTH,
    parameter int AW = REC_AW
)(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= mem[raddr];
        end
    end

endmodule

/* File: rtl/arcfp_light_sel.sv */
// light source selection for one stage or the delayed output
`timescale 1ns/1ps
module arcfp_light_sel
    import arcfp_pkg::*;
(
    input wire logic [SRC_W-1:0] sel,
    input wire logic sensorOne,
    input wire logic sensorTwo,
    input wire logic cardLight,
    output logic light
);

    // ------------------------------------------------------------
    // each select bit enables one source, none gives no light
    // ------------------------------------------------------------
    assign light = |(sel & {cardLight, sensorTwo, sensorOne});

endmodule

/* File: rtl/arcfp_pkg.sv */
// constants and types shared by the arc fault protection stages
package arcfp_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int NSTG = 4;
    localparam int CUR_W = 16;
    localparam int CNT_W = 16;
    localparam int SRC_W = 3;
    localparam int DLY_W = 16;
    localparam int FTO_W = 36;
    localparam int TICK_W = 17;
    localparam int MTX_W = 10;
    localparam int TS_W = 48;
    localparam int TYP_W = 8;
    localparam int ELAPSED_DELAY_PERCENT_W = 8;
    localparam int REC_DEPTH = 8;
    localparam int REC_AW = 3;
    localparam int REC_W = TS_W + 2 + CUR_W + ELAPSED_DELAY_PERCENT_W + TYP_W + CUR_W;

    // ------------------------------------------------------------
    // light source codes: bit0 sensor one, bit1 sensor two, bit2 card
    // ------------------------------------------------------------
    localparam logic [SRC_W-1:0] SRC_NONE = 3'h0;
    localparam logic [SRC_W-1:0] SRC_ALL = 3'h7;

    // ------------------------------------------------------------
    // configuration selects
    // ------------------------------------------------------------
    localparam logic [1:0] CFG_GRP_PICKUP = 2'h0;
    localparam logic [1:0] CFG_GRP_SRC = 2'h1;
    localparam logic [3:0] CFG_DLY_SRC = 4'h8;
    localparam logic [3:0] CFG_DLY_TIME = 4'h9;
    localparam logic [3:0] CFG_BO_MASK = 4'ha;
    localparam logic [3:0] CFG_FORCE = 4'hb;

    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [CUR_W-1:0] PU_ONE = 16'h0100;
    localparam logic [CUR_W-1:0] PICKUP_RST = PU_ONE;
    localparam logic [DLY_W-1:0] DLY_MS_RST = 16'h0064;
    localparam logic [MTX_W-1:0] BO_MASK_RST = 10'h000;
    localparam logic [ELAPSED_DELAY_PERCENT_W-1:0] ELAPSED_DELAY_PERCENT_TRIP = 8'h64;
    localparam int MTX_START = 0;
    localparam int MTX_TRIP = 4;
    localparam int MTX_CARD = 8;
    localparam int MTX_DLY = 9;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_FREQ_HZ = 100000000;
    localparam longint FORCE_TIMEOUT_MIN = 5;
    localparam longint FORCE_TIMEOUT_CYC = FORCE_TIMEOUT_MIN * 60 * CLK_FREQ_HZ;
    localparam longint DLY_TICK_MS = 1;
    localparam longint DLY_TICK_CYC = CLK_FREQ_HZ * DLY_TICK_MS / 1000;

    // ------------------------------------------------------------
    // state of the protection block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NSTG-1:0][CUR_W-1:0] pickup;
        logic [NSTG-1:0][SRC_W-1:0] src;
        logic [SRC_W-1:0] dlySrc;
        logic [DLY_W-1:0] dlyMs;
        logic [MTX_W-1:0] boMask;
        logic forceOn;
        logic [FTO_W-1:0] forceCnt;
        logic [NSTG-1:0] fStart;
        logic [NSTG-1:0] fTrip;
        logic [NSTG-1:0] start;
        logic [NSTG-1:0] trip;
        logic [NSTG-1:0] selPrev;
        logic rawPrev;
        logic [NSTG-1:0][CNT_W-1:0] lCnt;
        logic [NSTG-1:0][CNT_W-1:0] sCnt;
        logic [NSTG-1:0][CNT_W-1:0] tCnt;
        logic [TICK_W-1:0] tickCnt;
        logic [DLY_W-1:0] dlyElapsed;
        logic delayed;
        logic cardIn;
        logic cardOut;
        logic [REC_AW-1:0] recPtr;
    } arcfp_state_s;

endpackage

/* File: rtl/arcfp_top.sv */
// arc fault protection: four light and current stages with counters
// Function
// - four stages: two phase stages, two residual current stages
// - eight light source choices per stage; none operates only on forced status
// - start follows selected light regardless of current
// - trip needs selected light and current above pickup together
// - phase stages use highest phase current, earth stages residual
// - pickup held in per unit, one unit is rated input
// - raw light counter counts any sensor or card light
// - selected counter counts chosen light only; trip counter counts trips
// - counters accumulate and clear on request; a clear with an event leaves one
// - one shared force flag, cleared five minutes after setting
// - forced start and trip writes only while force is on
// - settings accepted only while operator is authorised
// - delayed light output with own source and delay
// - card input is light from another relay, routable
// - card output drives signals chosen by the output matrix
// - eight latest faults recorded with time, value, delay percent
`timescale 1ns/1ps
module arcfp_top
    import arcfp_pkg::*;
#(
    parameter logic [FTO_W-1:0] FORCE_CYC = FTO_W'(FORCE_TIMEOUT_CYC),
    parameter logic [TICK_W-1:0] TICK_CYC = TICK_W'(DLY_TICK_CYC)
)(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic light_sensor_one,
    input wire logic light_sensor_two,
    input wire logic card_light_input,
    input wire logic [3*CUR_W-1:0] phaseCurOne,
    input wire logic [3*CUR_W-1:0] phaseCurTwo,
    input wire logic [CUR_W-1:0] residual_current_one,
    input wire logic [CUR_W-1:0] residual_current_two,
    input wire logic cfgAuth,
    input wire logic cfgWe,
    input wire logic [3:0] cfgSel,
    input wire logic [CUR_W-1:0] cfgData,
    input wire logic forceWe,
    input wire logic [1:0] forceIdx,
    input wire logic forceStartVal,
    input wire logic forceTripVal,
    input wire logic [NSTG-1:0] cntClr,
    input wire logic [TS_W-1:0] timeStamp,
    input wire logic [TYP_W-1:0] faultType,
    input wire logic [CUR_W-1:0] preFaultLoad,
    input wire logic [REC_AW-1:0] recRdAddr,
    output logic [REC_W-1:0] recRdData,
    output logic [REC_AW-1:0] recWrPtr,
    output logic [NSTG-1:0] stageStart,
    output logic [NSTG-1:0] stageTrip,
    output logic forceOn,
    output logic delayedLight,
    output logic cardLightRoute,
    output logic card_light_output,
    output logic [NSTG*CNT_W-1:0] raw_light_counter,
    output logic [NSTG*CNT_W-1:0] selected_light_counter,
    output logic [NSTG*CNT_W-1:0] trip_counter
);

    // ------------------------------------------------------------
    // state and supervised values
    // ------------------------------------------------------------
    arcfp_state_s s_r;
    arcfp_state_s s_nxt;
    logic [NSTG-1:0][CUR_W-1:0] supv;
    logic [NSTG-1:0] selL;
    logic [NSTG-1:0] overCur;
    logic [NSTG-1:0] startNow;
    logic [NSTG-1:0] tripNow;
    logic [NSTG-1:0] tripRise;
    logic dlyLight;
    logic anyLight;
    logic [1:0] recStage;
    logic [REC_W-1:0] recData;

    function automatic logic [CUR_W-1:0] max3(
        input logic [3*CUR_W-1:0] v
    );
        logic [CUR_W-1:0] m;
        m = v[CUR_W-1:0];
        if (v[2*CUR_W-1:CUR_W] > m) begin
            m = v[2*CUR_W-1:CUR_W];
        end
        if (v[3*CUR_W-1:2*CUR_W] > m) begin
            m = v[3*CUR_W-1:2*CUR_W];
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // stage inputs
    // ------------------------------------------------------------
    assign supv[0] = max3(phaseCurOne);
    assign supv[1] = max3(phaseCurTwo);
    assign supv[2] = residual_current_one;
    assign supv[3] = residual_current_two;
    assign anyLight = light_sensor_one | light_sensor_two
        | card_light_input;

    generate
        for (genvar i = 0; i < NSTG; i++) begin : g_stage
            arcfp_light_sel u_sel (
                .sel(s_r.src[i]),
                .sensorOne(light_sensor_one),
                .sensorTwo(light_sensor_two),
                .cardLight(card_light_input),
                .light(selL[i])
            );
            assign overCur[i] = supv[i] > s_r.pickup[i];
            assign startNow[i] = selL[i]
                | (s_r.forceOn & s_r.fStart[i]);
            assign tripNow[i] = (selL[i] & overCur[i])
                | (s_r.forceOn & s_r.fTrip[i]);
            assign tripRise[i] = tripNow[i] & ~s_r.trip[i];
        end
    endgenerate

    arcfp_light_sel u_dly_sel (
        .sel(s_r.dlySrc),
        .sensorOne(light_sensor_one),
        .sensorTwo(light_sensor_two),
        .cardLight(card_light_input),
        .light(dlyLight)
    );

    // ------------------------------------------------------------
    // fault record
    // ------------------------------------------------------------
    always_comb begin
        recStage = 2'h0;
        for (int i = NSTG - 1; i >= 0; i--) begin
            if (tripRise[i]) begin
                recStage = 2'(i);
            end
        end
    end

    assign recData = {timeStamp, recStage, supv[recStage], ELAPSED_DELAY_PERCENT_TRIP,
        (recStage == 2'h0) ? faultType : 8'h00,
        (recStage == 2'h0) ? preFaultLoad : 16'h0000};

    arcfp_fault_mem u_rec (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ce(ce),
        .we(|tripRise),
        .waddr(s_r.recPtr),
        .wdata(recData),
        .raddr(recRdAddr),
        .rdata(recRdData)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [MTX_W-1:0] mtx;
        mtx = '0;
        s_nxt = s_r;
        if (cfgWe && cfgAuth) begin
            if (cfgSel[3:2] == CFG_GRP_PICKUP) begin
                s_nxt.pickup[cfgSel[1:0]] = cfgData;
            end else if (cfgSel[3:2] == CFG_GRP_SRC) begin
                s_nxt.src[cfgSel[1:0]] = cfgData[SRC_W-1:0];
            end else if (cfgSel == CFG_DLY_SRC) begin
                s_nxt.dlySrc = cfgData[SRC_W-1:0];
            end else if (cfgSel == CFG_DLY_TIME) begin
                s_nxt.dlyMs = cfgData;
            end else if (cfgSel == CFG_BO_MASK) begin
                s_nxt.boMask = cfgData[MTX_W-1:0];
            end
        end
        if (cfgWe && cfgAuth && cfgSel == CFG_FORCE) begin
            s_nxt.forceOn = cfgData[0];
            s_nxt.forceCnt = '0;
        end else if (s_r.forceOn) begin
            if (s_r.forceCnt >= FORCE_CYC - 1'b1) begin
                s_nxt.forceOn = 1'b0;
            end else begin
                s_nxt.forceCnt = s_r.forceCnt + 1'b1;
            end
        end
        if (!s_nxt.forceOn) begin
            s_nxt.fStart = '0;
            s_nxt.fTrip = '0;
        end else if (forceWe && s_r.forceOn) begin
            s_nxt.fStart[forceIdx] = forceStartVal;
            s_nxt.fTrip[forceIdx] = forceTripVal;
        end
        // status and counters; an event beats a clear
        s_nxt.start = startNow;
        s_nxt.trip = tripNow;
        s_nxt.selPrev = selL;
        s_nxt.rawPrev = anyLight;
        for (int i = 0; i < NSTG; i++) begin
            if (cntClr[i]) begin
                s_nxt.lCnt[i] = '0;
                s_nxt.sCnt[i] = '0;
                s_nxt.tCnt[i] = '0;
            end
            if (anyLight && !s_r.rawPrev) begin
                s_nxt.lCnt[i] = s_nxt.lCnt[i] + 1'b1;
            end
            if (selL[i] && !s_r.selPrev[i]) begin
                s_nxt.sCnt[i] = s_nxt.sCnt[i] + 1'b1;
            end
            if (tripRise[i]) begin
                s_nxt.tCnt[i] = s_nxt.tCnt[i] + 1'b1;
            end
        end
        if (|tripRise) begin
            s_nxt.recPtr = s_r.recPtr + 1'b1;
        end
        if (!dlyLight) begin
            s_nxt.tickCnt = '0;
            s_nxt.dlyElapsed = '0;
            s_nxt.delayed = 1'b0;
        end else begin
            if (s_r.tickCnt >= TICK_CYC - 1'b1) begin
                s_nxt.tickCnt = '0;
                if (s_r.dlyElapsed != '1) begin
                    s_nxt.dlyElapsed = s_r.dlyElapsed + 1'b1;
                end
            end else begin
                s_nxt.tickCnt = s_r.tickCnt + 1'b1;
            end
            s_nxt.delayed = s_nxt.dlyElapsed >= s_r.dlyMs;
        end
        s_nxt.cardIn = card_light_input;
        mtx[MTX_START +: NSTG] = startNow;
        mtx[MTX_TRIP +: NSTG] = tripNow;
        mtx[MTX_CARD] = card_light_input;
        mtx[MTX_DLY] = s_r.delayed;
        s_nxt.cardOut = |(mtx & s_r.boMask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
            s_r.pickup <= {NSTG{PICKUP_RST}};
            s_r.src <= {NSTG{SRC_NONE}};
            s_r.dlySrc <= SRC_NONE;
            s_r.dlyMs <= DLY_MS_RST;
            s_r.boMask <= BO_MASK_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign stageStart = s_r.start;
    assign stageTrip = s_r.trip;
    assign forceOn = s_r.forceOn;
    assign delayedLight = s_r.delayed;
    assign cardLightRoute = s_r.cardIn;
    assign card_light_output = s_r.cardOut;
    assign recWrPtr = s_r.recPtr;
    assign raw_light_counter = s_r.lCnt;
    assign selected_light_counter = s_r.sCnt;
    assign trip_counter = s_r.tCnt;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence sForceArm;
        ce && cfgWe && cfgAuth && cfgSel == CFG_FORCE && cfgData[0];
    endsequence

    sequence sForceIdle;
        ce && !(cfgWe && cfgAuth && cfgSel == CFG_FORCE);
    endsequence

    chk_none_src_idle: assert property (
        (ce && s_r.src[0] == SRC_NONE && !s_r.forceOn) |=> !s_r.start[0])
        else $error("stage with no source started");

    chk_start_on_light: assert property (
        (ce && selL[1]) |=> s_r.start[1])
        else $error("start missing while light seen");

    chk_trip_cause: assert property (
        (ce && !s_r.forceOn) ##1 s_r.trip[2]
            |-> $past(selL[2] && overCur[2]))
        else $error("trip without light and overcurrent");

    chk_phase_max_trip: assert property (
        (ce && selL[0] && phaseCurOne[3*CUR_W-1:2*CUR_W] > s_r.pickup[0])
            |=> s_r.trip[0])
        else $error("highest phase current ignored");

    chk_raw_light_cnt: assert property (
        (ce && anyLight && !s_r.rawPrev && !cntClr[3])
            |=> s_r.lCnt[3] == $past(s_r.lCnt[3]) + 1'b1)
        else $error("raw light counter missed an event");

    chk_trip_cnt: assert property (
        (ce && tripRise[0] && !cntClr[0])
            |=> s_r.tCnt[0] == $past(s_r.tCnt[0]) + 1'b1)
        else $error("trip counter missed a trip");

    chk_cnt_clear: assert property (
        (ce && cntClr[1] && !tripRise[1]) |=> s_r.tCnt[1] == '0)
        else $error("counter not cleared");

    chk_force_arm: assert property (
        sForceArm |=> s_r.forceOn && s_r.forceCnt == '0)
        else $error("force flag not set by write");

    chk_force_timeout: assert property (
        (sForceIdle ##0 s_r.forceOn && s_r.forceCnt >= FORCE_CYC - 1'b1)
            |=> !s_r.forceOn)
        else $error("force flag outlived its timeout");

    chk_forced_write_gated: assert property (
        (ce && forceWe && !s_r.forceOn) |=> s_r.fStart == '0)
        else $error("forced status taken without force flag");

    chk_cfg_auth: assert property (
        (ce && !cfgAuth) |=> $stable(s_r.pickup) && $stable(s_r.src))
        else $error("setting changed without authorisation");

    chk_rec_advance: assert property (
        (ce && |tripRise) |=> s_r.recPtr == $past(s_r.recPtr) + 1'b1)
        else $error("fault record pointer stuck");

    chk_delayed_drop: assert property (
        (ce && !dlyLight) |=> !s_r.delayed)
        else $error("delayed light held without light");

endmodule

/* File: testbench/arcfp_field_model.sv */
// light sensors, card input and current transformers seen by the block
`timescale 1ns/1ps
module arcfp_field_model
    import arcfp_pkg::*;
(
    input wire logic [2:0] lite,
    input wire logic [3*CUR_W-1:0] phOne,
    input wire logic [3*CUR_W-1:0] phTwo,
    input wire logic [CUR_W-1:0] resOne,
    input wire logic [CUR_W-1:0] resTwo,
    output logic sensorOne,
    output logic sensorTwo,
    output logic cardIn,
    output logic [3*CUR_W-1:0] curOne,
    output logic [3*CUR_W-1:0] curTwo,
    output logic [CUR_W-1:0] rOne,
    output logic [CUR_W-1:0] rTwo
);
    // ------------------------------------------------------------
    // sensors and a neighbouring relay hold levels as commanded
    // ------------------------------------------------------------
    assign sensorOne = lite[0];
    assign sensorTwo = lite[1];
    assign cardIn = lite[2];
    assign curOne = phOne;
    assign curTwo = phTwo;
    assign rOne = resOne;
    assign rTwo = resTwo;
endmodule

/* File: testbench/arcfp_top_test.sv */
// self-checking bench for the arc fault protection stages
`timescale 1ns/1ps
module arcfp_top_test;
    import arcfp_pkg::*;
    logic sys_clk = 0, arst_n = 0, cfgAuth = 0, cfgWe = 0, forceWe = 0;
    logic ce = 1;
    logic [2:0] lite = 0;
    logic [47:0] phOne = 0, phTwo = 0;
    logic [15:0] resOne = 0, resTwo = 0, cfgData = 0;
    logic [3:0] cfgSel = 0, cntClr = 0;
    logic [1:0] forceIdx = 0;
    logic fSt = 0, fTr = 0;
    logic [2:0] recRdAddr = 0, recWrPtr;
    logic s1, s2, ci, route, bo, fOn, dly;
    logic [47:0] c1, c2;
    logic [15:0] r1, r2;
    logic [97:0] rec;
    logic [3:0] st, tr;
    logic [63:0] rawC, selC, trC;
    int error_cnt = 0, num_checks = 0, cycles = 0;
    always #5 sys_clk = ~sys_clk;
    arcfp_field_model fm (.lite(lite), .phOne(phOne), .phTwo(phTwo),
        .resOne(resOne), .resTwo(resTwo), .sensorOne(s1), .sensorTwo(s2),
        .cardIn(ci), .curOne(c1), .curTwo(c2), .rOne(r1), .rTwo(r2));
    arcfp_top #(.FORCE_CYC(36'h32), .TICK_CYC(17'h4)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .ce(ce),
        .light_sensor_one(s1), .light_sensor_two(s2),
        .card_light_input(ci), .phaseCurOne(c1), .phaseCurTwo(c2),
        .residual_current_one(r1), .residual_current_two(r2),
        .cfgAuth(cfgAuth), .cfgWe(cfgWe), .cfgSel(cfgSel),
        .cfgData(cfgData), .forceWe(forceWe), .forceIdx(forceIdx),
        .forceStartVal(fSt), .forceTripVal(fTr), .cntClr(cntClr),
        .timeStamp(48'(cycles)), .faultType(8'h5a),
        .preFaultLoad(16'h0033), .recRdAddr(recRdAddr),
        .recRdData(rec), .recWrPtr(recWrPtr), .stageStart(st),
        .stageTrip(tr), .forceOn(fOn), .delayedLight(dly),
        .cardLightRoute(route), .card_light_output(bo),
        .raw_light_counter(rawC), .selected_light_counter(selC),
        .trip_counter(trC));
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic au, input logic [3:0] sel,
                       input logic [15:0] d);
        cfgAuth = au;
        cfgSel = sel;
        cfgData = d;
        cfgWe = 1;
        cyc(1);
        cfgWe = 0;
        cfgAuth = 0;
        cyc(1);
    endtask
    task automatic frc(input logic [1:0] i, input logic s, input logic t);
        forceIdx = i;
        fSt = s;
        fTr = t;
        forceWe = 1;
        cyc(1);
        forceWe = 0;
    endtask
    task automatic allSrc(input logic [15:0] s);
        for (int i = 0; i < 4; i++) cfg(1, 4'(4 + i), s);
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        cyc(2);
        arst_n = 1;
        chk({st, tr, fOn, dly, bo}, 0);
        chk(rawC | selC | trC, 0);
        cfg(1, 4'h4, 16'h0001);
        cfg(0, 4'h0, 16'h0200);
        lite = 1;
        phOne = 48'h0180;
        cyc(2);
        chk(tr, 4'h1);
        chk(recWrPtr, 3'h1);
        recRdAddr = 0;
        cyc(2);
        chk(rec[49:0], {2'h0, 16'h0180, 8'h64, 8'h5a, 16'h0033});
        lite = 0;
        cyc(1);
        cfg(1, 4'h0, 16'h0200);
        lite = 1;
        cyc(2);
        chk({st[0], tr[0]}, 2'b10);
        lite = 0;
        phOne = 0;
        for (int s = 0; s < 8; s++) begin
            cfg(1, 4'h4, 16'(s));
            for (int l = 0; l < 8; l++) begin
                lite = 3'(l);
                cyc(2);
                chk({st[0], tr[0]}, {|(s & l), 1'b0});
            end
        end
        allSrc(7);
        lite = 1;
        phTwo = 48'h0101_0000_0000;
        resTwo = 16'h0100;
        cyc(2);
        chk(tr, 4'h2);
        resTwo = 16'h0101;
        cyc(2);
        chk(tr, 4'ha);
        resOne = 16'h0101;
        cyc(2);
        chk(tr, 4'he);
        lite = 0;
        phTwo = 0;
        resTwo = 0;
        allSrc(2);
        cntClr = 4'hf;
        cyc(1);
        cntClr = 0;
        cyc(1);
        chk(rawC | selC | trC, 0);
        for (int p = 0; p < 5; p++) begin
            lite = (p < 3) ? 3'h1 : 3'h2;
            cyc(2);
            lite = 0;
            cyc(2);
        end
        chk({rawC[15:0], rawC[63:48]}, {16'h5, 16'h5});
        chk({selC[15:0], selC[63:48]}, {16'h2, 16'h2});
        chk(trC, 64'h0000_0002_0000_0000);
        resOne = 0;
        cntClr = 4'hf;
        cyc(1);
        cntClr = 0;
        cyc(1);
        chk(rawC | selC | trC, 0);
        frc(2'h1, 1, 1);
        cyc(2);
        chk({st, tr}, 0);
        cfg(1, 4'hb, 16'h0001);
        chk(fOn, 1);
        frc(2'h1, 1, 1);
        cyc(2);
        chk({st, tr}, 8'h22);
        cyc(35);
        chk(fOn, 1);
        cyc(25);
        chk({fOn, st, tr}, 0);
        cfg(1, 4'h8, 16'h0004);
        cfg(1, 4'h9, 16'h0003);
        lite = 4;
        cyc(11);
        chk(dly, 0);
        cyc(1);
        chk(dly, 1);
        lite = 1;
        cyc(1);
        chk(dly, 0);
        cfg(1, 4'ha, 16'h0100);
        lite = 4;
        cyc(3);
        chk({route, bo}, 2'b11);
        lite = 0;
        cyc(3);
        chk({route, bo}, 2'b00);
        cfg(1, 4'ha, 16'h000f);
        lite = 2;
        cyc(3);
        chk(bo, 1);
        ce = 0;
        lite = 0;
        cyc(2);
        chk(st, 4'hf);
        ce = 1;
        cyc(1);
        chk(st, 0);
        recRdAddr = 1;
        cyc(2);
        chk(rec[49:0], {2'h1, 16'h0101, 8'h64, 8'h00, 16'h0000});
        arst_n = 0;
        lite = 2;
        cyc(1);
        arst_n = 1;
        cyc(2);
        chk(st, 0);
        chk(rawC, 64'h0001_0001_0001_0001);
        end_of_test();
    end
endmodule
